// >>> core/quad_position_top.sv
// Quadrature position input: decoders, counter routing, position counters
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "quad_map.svh"

module quad_position_top
  import quad_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [1:0] PHASE_A_INPUT,
  input wire logic [1:0] PHASE_B_INPUT,
  input wire logic [1:0] ZERO_MARK,
  input wire logic [3:0] EXT_TICK_IN,
  input wire logic [3:0] EXT_GATE_IN,
  output logic [4:0] COUNTER_SOURCE_IN,
  output logic [4:0] COUNTER_GATE_IN,
  output logic [3:0] COUNT_OUT,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam int NCTR = `QP_NCTR;
  localparam int CTRW = `QP_CTR_W;

  logic [1:0] fwd_p;
  logic [1:0] rev_p;
  logic [1:0] ph_lvl [2];
  logic [3:0] dir_pulse;
  logic [1:0] mark_s1_q;
  logic [1:0] mark_s2_q;
  logic [1:0] mark_d_q;
  logic [1:0] mark_edge;
  logic [3:0] tick_s1_q;
  logic [3:0] tick_s2_q;
  logic [3:0] gate_s1_q;
  logic [3:0] gate_s2_q;
  route_t route_q;
  logic qsel_q;
  logic [11:0] ctrl_q;
  ctr_cfg_t cfg [NCTR];
  logic [3:0] snap_q;
  logic [3:0] loadnow_q;
  logic [CTRW-1:0] load_q [NCTR];
  logic [CTRW-1:0] hold_q [NCTR];
  logic [CTRW-1:0] count_q [NCTR];
  logic [3:0] pend_q;
  logic [3:0] use_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  reg_sel_t wsel;
  reg_sel_t rsel;
  logic [31:0] rd_word;

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic reg_sel_t decode(input logic [7:0] a);
    reg_sel_t s;
    s.kind = SEL_NONE;
    s.idx = a[3:2];
    if (a == `QP_OFS_QSEL) s.kind = SEL_QSEL;
    else if (a == `QP_OFS_CTRL) s.kind = SEL_CTRL;
    else if (a == `QP_OFS_STAT) s.kind = SEL_STAT;
    else if (a == `QP_OFS_CMD) s.kind = SEL_CMD;
    else if (a[1:0] == 2'h0) begin
      case (a[7:4])
        `QP_BLK_LOAD: s.kind = SEL_LOAD;
        `QP_BLK_HOLD: s.kind = SEL_HOLD;
        `QP_BLK_COUNT: s.kind = SEL_COUNT;
        default: s.kind = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  // ************************************************************
  // Decoders, one per channel
  // ************************************************************
  for (genvar c = 0; c < 2; c++) begin : g_dec
    quad_decoder u_dec (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .phase_a_input(PHASE_A_INPUT[c]),
      .phase_b_input(PHASE_B_INPUT[c]),
      .clockwise_pulse(fwd_p[c]),
      .counterclockwise_pulse(rev_p[c]),
      .phase_lvl(ph_lvl[c])
    );
  end

  assign dir_pulse = {rev_p[1], fwd_p[1], rev_p[0], fwd_p[0]};

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_s1_q <= 4'h0;
      tick_s2_q <= 4'h0;
      gate_s1_q <= 4'h0;
      gate_s2_q <= 4'h0;
      mark_s1_q <= 2'h0;
      mark_s2_q <= 2'h0;
      mark_d_q <= 2'h0;
    end else begin
      tick_s1_q <= EXT_TICK_IN;
      tick_s2_q <= tick_s1_q;
      gate_s1_q <= EXT_GATE_IN;
      gate_s2_q <= gate_s1_q;
      mark_s1_q <= ZERO_MARK;
      mark_s2_q <= mark_s1_q;
      mark_d_q <= mark_s2_q;
    end
  end

  assign mark_edge = mark_s2_q & ~mark_d_q;

  // ************************************************************
  // Input routing toward the timing controller
  // ************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      route_q <= '0;
    end else begin
      route_q.src[1:0] <= tick_s2_q[1:0];
      route_q.src[2] <= qsel_q ? fwd_p[1] : tick_s2_q[2];
      route_q.src[3] <= qsel_q ? rev_p[1] : tick_s2_q[3];
      route_q.src[4] <= fwd_p[0];
      route_q.gate[3:0] <= gate_s2_q;
      route_q.gate[4] <= rev_p[0];
    end
  end

  assign COUNTER_SOURCE_IN = route_q.src;
  assign COUNTER_GATE_IN = route_q.gate;

  // ************************************************************
  // Register bus: write path
  // ************************************************************
  // Address and data may arrive in either order; the write fires once both
  // are held and no response is outstanding.
  assign wr_fire = ~S_AXI_AWREADY & ~S_AXI_WREADY & ~S_AXI_BVALID;
  assign wsel = decode(awaddr_q);

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b1;
      awaddr_q <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      S_AXI_AWREADY <= 1'b0;
      awaddr_q <= S_AXI_AWADDR;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_WREADY <= 1'b1;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      S_AXI_WREADY <= 1'b0;
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `QP_RESP_OK;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      // Status and count words are read-only
      S_AXI_BRESP <= (wsel.kind == SEL_NONE || wsel.kind == SEL_STAT ||
                      wsel.kind == SEL_COUNT) ? `QP_RESP_ERR : `QP_RESP_OK;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      qsel_q <= `QP_QSEL_RST;
    end else if (wr_fire && wsel.kind == SEL_QSEL && wstrb_q[0]) begin
      qsel_q <= wdata_q[`QP_QSEL_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q <= `QP_CTRL_RST;
    end else if (wr_fire && wsel.kind == SEL_CTRL) begin
      ctrl_q <= 12'(merge16({4'h0, ctrl_q}, wdata_q, wstrb_q));
    end
  end

  // Command bits are one-cycle pulses; they never store
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      snap_q <= 4'h0;
      loadnow_q <= 4'h0;
    end else if (wr_fire && wsel.kind == SEL_CMD && wstrb_q[0] &&
                 wstrb_q[1]) begin
      snap_q <= wdata_q[`QP_CMD_SNAP_LSB +: 4];
      loadnow_q <= wdata_q[`QP_CMD_LOAD_LSB +: 4];
    end else begin
      snap_q <= 4'h0;
      loadnow_q <= 4'h0;
    end
  end

  // ************************************************************
  // Position counters, two per channel
  // ************************************************************
  for (genvar i = 0; i < NCTR; i++) begin : g_ctr
    logic pulse;
    logic marker;

    assign cfg[i] = '{alt_load: ctrl_q[`QP_CTRL_ALT_LSB + i],
                      retrig: ctrl_q[`QP_CTRL_RETRIG_LSB + i],
                      armed: ctrl_q[`QP_CTRL_ARM_LSB + i]};
    assign pulse = dir_pulse[i] & cfg[i].armed;
    assign marker = mark_edge[i/2] & cfg[i].retrig;

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        load_q[i] <= `QP_WORD_RST;
      end else if (wr_fire && wsel.kind == SEL_LOAD && wsel.idx == 2'(i)) begin
        load_q[i] <= merge16(load_q[i], wdata_q, wstrb_q);
      end
    end

    // A hardware snapshot wins over a software write in the same cycle
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        hold_q[i] <= `QP_WORD_RST;
      end else if (marker) begin
        hold_q[i] <= count_q[i];
      end else if (snap_q[i]) begin
        hold_q[i] <= count_q[i];
      end else if (wr_fire && wsel.kind == SEL_HOLD &&
                   wsel.idx == 2'(i)) begin
        hold_q[i] <= merge16(hold_q[i], wdata_q, wstrb_q);
      end
    end

    // Marker pending: set wins over the clearing count pulse
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        pend_q[i] <= 1'b0;
      end else if (marker) begin
        pend_q[i] <= 1'b1;
      end else if (pulse) begin
        pend_q[i] <= 1'b0;
      end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        count_q[i] <= `QP_WORD_RST;
        COUNT_OUT[i] <= 1'b0;
        use_hold_q[i] <= 1'b0;
      end else if (loadnow_q[i]) begin
        count_q[i] <= load_q[i];
        use_hold_q[i] <= 1'b0;
      end else if (pulse) begin
        if (pend_q[i]) begin
          count_q[i] <= load_q[i];
        end else if (count_q[i] == `QP_CTR_MAX) begin
          // Terminal count: toggle and reload, alternating when asked
          count_q[i] <= use_hold_q[i] ? hold_q[i] : load_q[i];
          COUNT_OUT[i] <= ~COUNT_OUT[i];
          use_hold_q[i] <= cfg[i].alt_load & ~use_hold_q[i];
        end else begin
          count_q[i] <= count_q[i] + 16'h0001;
        end
      end
    end
  end

  // ************************************************************
  // Register bus: read path
  // ************************************************************
  assign rsel = decode(S_AXI_ARADDR);

  always_comb begin
    rd_word = 32'h00000000;
    case (rsel.kind)
      SEL_QSEL: rd_word[`QP_QSEL_BIT] = qsel_q;
      SEL_CTRL: rd_word[11:0] = ctrl_q;
      SEL_STAT: begin
        rd_word[`QP_STAT_PHASE_LSB +: 4] = {ph_lvl[1], ph_lvl[0]};
        rd_word[`QP_STAT_OUT_LSB +: 4] = COUNT_OUT;
        rd_word[`QP_STAT_PEND_LSB +: 4] = pend_q;
      end
      SEL_LOAD: rd_word[15:0] = load_q[rsel.idx];
      SEL_HOLD: rd_word[15:0] = hold_q[rsel.idx];
      SEL_COUNT: rd_word[15:0] = count_q[rsel.idx];
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `QP_RESP_OK;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= (rsel.kind == SEL_NONE) ? `QP_RESP_ERR : `QP_RESP_OK;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule : quad_position_top

`default_nettype wire

// >>> pkg/quad_map.svh
// Register offsets, field positions, reset values and sizes of the block
`ifndef QUAD_MAP_SVH
`define QUAD_MAP_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define QP_OFS_QSEL 8'h00
`define QP_OFS_CTRL 8'h04
`define QP_OFS_STAT 8'h08
`define QP_OFS_CMD 8'h0C
`define QP_BLK_LOAD 4'h1
`define QP_BLK_HOLD 4'h2
`define QP_BLK_COUNT 4'h3

// ************************************************************
// Field positions
// ************************************************************
`define QP_QSEL_BIT 0
`define QP_CTRL_ARM_LSB 0
`define QP_CTRL_RETRIG_LSB 4
`define QP_CTRL_ALT_LSB 8
`define QP_CMD_SNAP_LSB 0
`define QP_CMD_LOAD_LSB 8
`define QP_STAT_PHASE_LSB 0
`define QP_STAT_OUT_LSB 4
`define QP_STAT_PEND_LSB 8

// ************************************************************
// Sizes and reset values
// ************************************************************
`define QP_NCTR 4
`define QP_CTR_W 16
`define QP_CTR_MAX 16'hFFFF
`define QP_QSEL_RST 1'h0
`define QP_CTRL_RST 12'h000
`define QP_WORD_RST 16'h0000
`define QP_RESP_OK 2'h0
`define QP_RESP_ERR 2'h2

`endif

// >>> pkg/quad_pkg.sv
// Types shared by the quadrature position block
package quad_pkg;

  // Phase pair {a,b}; the usual path is a Gray walk
  typedef enum logic [1:0] {
    PH_00 = 2'h0,
    PH_10 = 2'h2,
    PH_11 = 2'h3,
    PH_01 = 2'h1
  } phase_t;

  typedef struct packed {
    logic alt_load;
    logic retrig;
    logic armed;
  } ctr_cfg_t;

  typedef struct packed {
    logic [4:0] src;
    logic [4:0] gate;
  } route_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_QSEL,
    SEL_CTRL,
    SEL_STAT,
    SEL_CMD,
    SEL_LOAD,
    SEL_HOLD,
    SEL_COUNT
  } sel_kind_t;

  typedef struct packed {
    sel_kind_t kind;
    logic [1:0] idx;
  } reg_sel_t;

endpackage : quad_pkg

// >>> core/quad_decoder.sv
// Quadrature decoder: synchronises one phase pair, emits direction pulses
`timescale 1ns/10ps
`default_nettype none

module quad_decoder
  import quad_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  output logic clockwise_pulse,
  output logic counterclockwise_pulse,
  output logic [1:0] phase_lvl
);

  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  phase_t state_q;
  phase_t now_ph;

  // Next position along the clockwise walk (phase a leads)
  function automatic phase_t fwd_next(input phase_t p);
    case (p)
      PH_00: fwd_next = PH_10;
      PH_10: fwd_next = PH_11;
      PH_11: fwd_next = PH_01;
      PH_01: fwd_next = PH_00;
      default: fwd_next = PH_00;
    endcase
  endfunction : fwd_next

  // ************************************************************
  // Two-stage synchroniser
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {phase_a_input, phase_b_input};
      sync2_q <= sync1_q;
    end
  end

  assign now_ph = phase_t'(sync2_q);

  // ************************************************************
  // Direction decode
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PH_00;
      clockwise_pulse <= 1'b0;
      counterclockwise_pulse <= 1'b0;
    end else begin
      state_q <= now_ph;
      // Both phases flipping at once has no direction, so it is dropped
      clockwise_pulse <= (now_ph == fwd_next(state_q));
      counterclockwise_pulse <= (state_q == fwd_next(now_ph));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_lvl <= 2'h0;
    end else begin
      phase_lvl <= sync2_q;
    end
  end

endmodule : quad_decoder

`default_nettype wire

// >>> dv/quad_position_assertions.sv
// Port-level checker for the quadrature position block
`timescale 1ns/10ps
`default_nettype none

module quad_position_assertions
  import quad_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [1:0] PHASE_A_INPUT,
  input wire logic [1:0] PHASE_B_INPUT,
  input wire logic [3:0] EXT_TICK_IN,
  input wire logic [3:0] EXT_GATE_IN,
  input wire logic [4:0] COUNTER_SOURCE_IN,
  input wire logic [4:0] COUNTER_GATE_IN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID
);
  logic [1:0] ph0;
  assign ph0 = {PHASE_A_INPUT[0], PHASE_B_INPUT[0]};

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  fixed_ticks_a: assert property (
    $stable(EXT_TICK_IN[1:0]) [*5] |->
      COUNTER_SOURCE_IN[1:0] == EXT_TICK_IN[1:0])
    else $error("sources 1-2 not following ticks");
  fixed_gates_a: assert property (
    $stable(EXT_GATE_IN) [*5] |-> COUNTER_GATE_IN[3:0] == EXT_GATE_IN)
    else $error("gates 1-4 not following gate pins");
  dir_exclusive_a: assert property (
    !(COUNTER_SOURCE_IN[4] && COUNTER_GATE_IN[4]))
    else $error("both directions pulsed on channel 0");
  pulse_cause_a: assert property (
    (COUNTER_SOURCE_IN[4] || COUNTER_GATE_IN[4]) |->
      $past(ph0, 3) != $past(ph0, 6))
    else $error("direction pulse without a phase change");
  pulse_single_a: assert property (
    COUNTER_SOURCE_IN[4] |=> !COUNTER_SOURCE_IN[4])
    else $error("clockwise pulse longer than one cycle");
  write_answer_a: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  read_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read response late");
  ready_low_a: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write channel ready during response");

  cover property (COUNTER_SOURCE_IN[4]);
  cover property (COUNTER_GATE_IN[4]);
  cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule : quad_position_assertions

bind quad_position_top quad_position_assertions chk_i (
  .SYS_CLK, .SYS_RST, .PHASE_A_INPUT, .PHASE_B_INPUT, .EXT_TICK_IN,
  .EXT_GATE_IN, .COUNTER_SOURCE_IN, .COUNTER_GATE_IN, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID);

`default_nettype wire

// >>> dv/quad_encoder_model.sv
// Behavioural two-channel shaft encoder with zero-marker outputs
`timescale 1ns/10ps
`default_nettype none

module quad_encoder_model
  import quad_pkg::*;
(
  input wire logic clk,
  output logic [1:0] pa,
  output logic [1:0] pb,
  output logic [1:0] zm
);
  logic [1:0] pos [2] = '{2'h0, 2'h0};
  logic [1:0] ab;

  initial begin
    pa = 2'h0;
    pb = 2'h0;
    zm = 2'h0;
  end

  // n = 1 clockwise, -1 counter-clockwise, 2 flips both phases at once
  task automatic move(input int ch, input int n);
    pos[ch] = pos[ch] + 2'(n);
    ab = pos[ch][1] ? {~pos[ch][0], 1'b1} : {pos[ch][0], 1'b0};
    @(posedge clk);
    pa[ch] <= ab[1];
    pb[ch] <= ab[0];
    // Slow steps leave the synchronisers settled between edges
    repeat (8) @(posedge clk);
  endtask : move

  task automatic mark(input int ch);
    @(posedge clk);
    zm[ch] <= 1'b1;
    repeat (4) @(posedge clk);
    zm[ch] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : mark
endmodule : quad_encoder_model

`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the quadrature position block
`timescale 1ns/10ps
`default_nettype none
`include "quad_map.svh"

module tb
  import quad_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] pa, pb, zm;
  logic [3:0] tick = 4'h0;
  logic [3:0] gate = 4'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [4:0] src, gte;
  logic [3:0] cout;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0, checks_done = 0, cyc = 0;
  int np [5] = '{default: 0};

  always #5 clk = ~clk;

  quad_encoder_model enc (.clk(clk), .pa(pa), .pb(pb), .zm(zm));

  quad_position_top dut (
    .SYS_CLK(clk), .SYS_RST(rst), .PHASE_A_INPUT(pa), .PHASE_B_INPUT(pb),
    .ZERO_MARK(zm), .EXT_GATE_IN(gate),
    // Marker also drives tick 0 so source 1 can count markers
    .EXT_TICK_IN({tick[3:1], tick[0] | zm[0]}),
    .COUNTER_SOURCE_IN(src), .COUNTER_GATE_IN(gte), .COUNT_OUT(cout),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  // Pulse tally for sources 3, 4, 5 and gate 5; high cycles of source 1
  always @(posedge clk) begin
    for (int k = 0; k < 3; k++) np[k] <= np[k] + int'(src[k+2]);
    np[3] <= np[3] + int'(gte[4]);
    np[4] <= np[4] + int'(src[0]);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write answer", 32'h1, 32'(bvalid));
    chk("write response", 32'(er), 32'(bresp));
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(nm, e, rdata);
    chk("read response", 32'(er), 32'(rresp));
  endtask : rc

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rc("select at reset", 8'h00, 32'h0, `QP_RESP_OK);
    rc("control at reset", 8'h04, 32'h0, `QP_RESP_OK);
    wr(8'h00, 32'hFE, 4'h1, `QP_RESP_OK);
    rc("select upper bits", 8'h00, 32'h0, `QP_RESP_OK);
    wr(8'h00, 32'hFF, 4'h1, `QP_RESP_OK);
    rc("select bit", 8'h00, 32'h1, `QP_RESP_OK);
    wr(8'h08, 32'h1, 4'hF, `QP_RESP_ERR);
    wr(8'h30, 32'h1, 4'hF, `QP_RESP_ERR);
    rc("unmapped", 8'h44, 32'h0, `QP_RESP_ERR);
    $display("registers test done");
  endtask : t_regs

  task automatic t_route();
    tick <= 4'hA;
    gate <= 4'h5;
    repeat (6) @(posedge clk);
    chk("sources 1-2", 32'h2, 32'(src[1:0]));
    chk("sources 3-4 quad", 32'h0, 32'(src[3:2]));
    chk("gates 1-4", 32'h5, 32'(gte[3:0]));
    wr(8'h00, 32'h0, 4'h1, `QP_RESP_OK);
    repeat (6) @(posedge clk);
    chk("sources 3-4 ticks", 32'h2, 32'(src[3:2]));
    wr(8'h00, 32'h1, 4'h1, `QP_RESP_OK);
    // Let the tick pulse still in the routing flop drain before tallying
    repeat (4) @(posedge clk);
    $display("routing test done");
  endtask : t_route

  task automatic t_count();
    int b [5];
    b = np;
    wr(8'h04, 32'h3F, 4'h3, `QP_RESP_OK);
    repeat (5) enc.move(0, 1);
    repeat (3) enc.move(0, -1);
    repeat (2) enc.move(1, 1);
    enc.move(1, -1);
    enc.move(0, 2);
    rc("count fwd 0", 8'h30, 32'h5, `QP_RESP_OK);
    rc("count rev 0", 8'h34, 32'h3, `QP_RESP_OK);
    rc("count fwd 1", 8'h38, 32'h2, `QP_RESP_OK);
    rc("count rev 1", 8'h3C, 32'h1, `QP_RESP_OK);
    chk("pulses source 3", 32'h2, 32'(np[0] - b[0]));
    chk("pulses source 4", 32'h1, 32'(np[1] - b[1]));
    chk("pulses source 5", 32'h5, 32'(np[2] - b[2]));
    chk("pulses gate 5", 32'h3, 32'(np[3] - b[3]));
    $display("counting test done");
  endtask : t_count

  task automatic t_marker();
    int b0;
    b0 = np[4];
    enc.mark(0);
    chk("marker on source 1", 32'h4, 32'(np[4] - b0));
    rc("hold fwd 0", 8'h20, 32'h5, `QP_RESP_OK);
    rc("hold rev 0", 8'h24, 32'h3, `QP_RESP_OK);
    rc("count kept", 8'h30, 32'h5, `QP_RESP_OK);
    enc.move(0, 1);
    rc("count reloaded", 8'h30, 32'h0, `QP_RESP_OK);
    enc.move(0, 1);
    rc("count resumes", 8'h30, 32'h1, `QP_RESP_OK);
    $display("marker test done");
  endtask : t_marker

  task automatic t_snap();
    // A command with only one byte lane must do nothing
    wr(8'h0C, 32'h4, 4'h1, `QP_RESP_OK);
    rc("hold one lane", 8'h28, 32'h0, `QP_RESP_OK);
    wr(8'h0C, 32'h4, 4'h3, `QP_RESP_OK);
    rc("hold snapshot", 8'h28, 32'h2, `QP_RESP_OK);
    enc.move(1, 1);
    rc("count goes on", 8'h38, 32'h3, `QP_RESP_OK);
    $display("snapshot test done");
  endtask : t_snap

  task automatic t_tc();
    wr(8'h1C, 32'hFFFE, 4'h3, `QP_RESP_OK);
    wr(8'h2C, 32'hFFFD, 4'h3, `QP_RESP_OK);
    wr(8'h04, 32'h83F, 4'h3, `QP_RESP_OK);
    wr(8'h0C, 32'h800, 4'h3, `QP_RESP_OK);
    rc("count loaded", 8'h3C, 32'hFFFE, `QP_RESP_OK);
    repeat (2) enc.move(1, -1);
    rc("reload from load", 8'h3C, 32'hFFFE, `QP_RESP_OK);
    chk("output toggled", 32'h1, 32'(cout[3]));
    repeat (2) enc.move(1, -1);
    rc("reload from hold", 8'h3C, 32'hFFFD, `QP_RESP_OK);
    chk("output back", 32'h0, 32'(cout[3]));
    rc("status", 8'h08, 32'h20F, `QP_RESP_OK);
    $display("terminal count test done");
  endtask : t_tc

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_route();
    t_count();
    t_marker();
    t_snap();
    t_tc();
    results();
  end
endmodule : tb

`default_nettype wire
